// [bench/neighbour_model.sv]
`timescale 1ns/1ps
// neighbour feeding the north lane; idle lanes carry a moving pattern
module neighbour_model (
	input wire logic pclk, // core clock
	input wire logic presetn, // async reset, low
	input wire logic slow, // pause after each word
	input wire logic [7:0] want, // words to send
	input wire logic [3:0] link_in_ready, // room at switch
	input wire logic [3:0] link_out_valid, // word from switch
	output logic [127:0] link_in_data, // words to switch
	output logic [3:0] link_in_valid, // lane valid
	output logic [3:0] link_credit_return // freed slot pulses
);
	logic [7:0] sent;
	logic [31:0] cyc;
	logic gap;
	// valid never waits on ready, so a word stays offered until taken
	assign link_in_valid = {3'h0, sent < want && !gap};
	assign link_in_data = {{3{cyc}}, link_in_valid[0] ? 32'ha500_0000 + 32'(sent) : ~cyc};
	// a slot comes back one cycle after each word arrives
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sent <= 8'h0;
			cyc <= 32'h0;
			gap <= 1'b0;
			link_credit_return <= 4'h0;
		end
		else
		begin
			cyc <= cyc + 32'h1;
			link_credit_return <= link_out_valid;
			if (gap)
				gap <= 1'b0;
			else if (link_in_valid[0] && link_in_ready[0])
			begin
				sent <= sent + 8'h1;
				gap <= slow;
			end
		end
	end
endmodule // neighbour_model

// [bench/static_mesh_switch_state_regs_tb.sv]
`timescale 1ns/1ps
module static_mesh_switch_state_regs_tb;
	localparam logic [7:0] a_dat = mesh_switch_pkg::off_fifo_port;
	localparam logic [7:0] a_ch = mesh_switch_pkg::off_fifo_choice;
	localparam logic [7:0] a_in = mesh_switch_pkg::off_input_fill_counts;
	localparam logic [7:0] a_out = mesh_switch_pkg::off_output_credit_counts;
	localparam logic [7:0] a_rt = mesh_switch_pkg::off_route_select;
	localparam logic [7:0] a_st = mesh_switch_pkg::off_irq_status;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, fabric_hold, irq, priv, alt_priv, slow, e;
	logic [7:0] paddr, want;
	logic [31:0] pwdata, prdata, r, w;
	logic [2:0] pprot;
	logic [127:0] in_data, out_data;
	logic [3:0] in_valid, in_ready, out_valid, credit;
	int bad_count, samples_checked, seed, i, west_seen;
	logic [31:0] q[$];
	static_mesh_switch_state_regs static_mesh_switch_state_regs_i (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pprot(pprot),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .switch_privilege_level(priv),
		.alt_switch_privilege_level(alt_priv), .link_in_data(in_data), .link_in_valid(in_valid),
		.link_in_ready(in_ready), .link_out_data(out_data), .link_out_valid(out_valid),
		.link_credit_return(credit), .fabric_hold(fabric_hold), .irq(irq));
	neighbour_model neighbour_model_i (.pclk(pclk), .presetn(presetn), .slow(slow), .want(want),
		.link_in_ready(in_ready), .link_out_valid(out_valid), .link_in_data(in_data),
		.link_in_valid(in_valid), .link_credit_return(credit));
	// west lane monitor: words leave in the order the neighbour sent them
	always @(negedge pclk)
		if (presetn === 1'b1 && out_valid[3] === 1'b1)
		begin
			chk("west out", out_data[127:96], 32'ha500_0003 + 32'(west_seen));
			west_seen++;
		end
	initial
	begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
		samples_checked++;
		if (s !== x)
		begin
			bad_count++;
			$display("[ERR] %s exp %h got %h", n, x, s);
		end
	endtask
	// one transfer, held until pready is seen high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x, input string n);
		apb(1'b0, a, 32'h0);
		chk(n, r, x);
	endtask
	task automatic final_report;
		$display("checked %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial
	begin
		repeat (20000) @(posedge pclk);
		bad_count++;
		final_report;
	end
	initial
	begin
		seed = 60;
		{psel, penable, pwrite, paddr, pwdata, pprot, want, slow} = '0;
		{priv, alt_priv, presetn} = 3'b110;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		chk("hold", 32'(fabric_hold), 32'h1);
		rd(mesh_switch_pkg::off_control, mesh_switch_pkg::control_reset, "ctl");
		for (i = 2; i < 7; i++) rd(8'(4 * i), 32'h0, "rst");
		// selector codes 0 to 5 in all five fields, junk in reserved bits
		for (i = 0; i < 6; i++)
		begin
			w = 32'(i) * 32'h1249;
			apb(1'b1, a_rt, w | ($random(seed) & 32'hffff_8000));
			rd(a_rt, w, "route");
		end
		for (i = 0; i < 8; i++)
		begin
			apb(1'b1, a_ch, 32'(i) | ($random(seed) & 32'hffff_fff8));
			rd(a_ch, 32'(i), "choice");
		end
		// frozen fabric: processor input fifo only moves by software
		apb(1'b1, a_ch, 32'(mesh_switch_pkg::sel_proc_in));
		for (i = 0; i < 3; i++)
		begin
			w = $random(seed);
			q.push_back(w);
			apb(1'b1, a_dat, w);
		end
		rd(a_in, 32'h0003_0000, "in cnt");
		for (i = 0; i < 3; i++) rd(a_dat, q.pop_front(), "pop in");
		rd(a_in, 32'h0, "in empty");
		apb(1'b1, a_ch, 32'(mesh_switch_pkg::sel_proc_out));
		for (i = 0; i < 2; i++)
		begin
			w = $random(seed);
			q.push_back(w);
			apb(1'b1, a_dat, w);
		end
		rd(a_out, 32'h0002_0000, "out cnt");
		rd(mesh_switch_pkg::off_rx_ready_flag, 32'h1, "ready");
		@(negedge pclk);
		chk("irq masked", 32'(irq), 32'h0);
		apb(1'b1, mesh_switch_pkg::off_irq_mask, 32'h3);
		@(negedge pclk);
		chk("irq up", 32'(irq), 32'h1);
		for (i = 0; i < 2; i++) rd(a_dat, q.pop_front(), "pop out");
		apb(1'b1, a_st, 32'h1);
		@(negedge pclk);
		chk("irq clr", 32'(irq), 32'h0);
		// undefined choice: word dropped, read zero, event flagged
		apb(1'b1, a_ch, 32'h6);
		apb(1'b1, a_dat, $random(seed));
		rd(a_dat, 32'h0, "bad rd");
		rd(a_in, 32'h0, "bad in");
		rd(a_st, 32'h2, "bad st");
		apb(1'b1, a_st, 32'h2);
		rd(8'h24, 32'h0, "unmapped");
		chk("unmapped err", 32'(e), 32'h1);
		priv <= 1'b0;
		rd(a_ch, 32'h0, "no priv");
		chk("priv err", 32'(e), 32'h1);
		priv <= 1'b1;
		apb(1'b1, a_ch | mesh_switch_pkg::off_alt_bank, 32'h3);
		rd(a_ch, 32'h3, "alt shared");
		alt_priv <= 1'b0;
		rd(a_ch | mesh_switch_pkg::off_alt_bank, 32'h0, "alt locked");
		chk("alt err", 32'(e), 32'h1);
		alt_priv <= 1'b1;
		apb(1'b1, a_out, 32'h0000_3210);
		rd(a_out, 32'h0000_3210, "credits");
		// live fabric: north input routed to the processor output
		apb(1'b1, a_rt, 32'h0000_1000);
		apb(1'b1, mesh_switch_pkg::off_control, 32'h0);
		@(negedge pclk);
		chk("thaw", 32'(fabric_hold), 32'h0);
		slow <= 1'b1;
		want <= 8'h3;
		apb(1'b0, a_out, 32'h0);
		for (i = 0; i < 40 && r[19:16] !== 4'h3; i++) apb(1'b0, a_out, 32'h0);
		rd(a_out, 32'h0003_3210, "routed cnt");
		apb(1'b1, a_ch, 32'(mesh_switch_pkg::sel_proc_out));
		for (i = 0; i < 3; i++) rd(a_dat, 32'ha500_0000 + 32'(i), "routed");
		rd(mesh_switch_pkg::off_rx_ready_flag, 32'h0, "drained");
		// north input steered to the west output, paced by its credits
		apb(1'b1, a_rt, 32'h0000_0200);
		want <= 8'h6;
		for (i = 0; i < 40 && west_seen < 3; i++) apb(1'b0, a_out, 32'h0);
		chk("west cnt", 32'(west_seen), 32'h3);
		rd(a_out, 32'h0000_3210, "credit back");
		final_report;
	end
endmodule // static_mesh_switch_state_regs_tb

// [bench/switch_regs_asserts.sv]
`timescale 1ns/1ps
module switch_regs_asserts (
	input wire logic pclk, // core clock
	input wire logic presetn, // async reset, low
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction
	input wire logic [7:0] paddr, // apb address
	input wire logic [31:0] pwdata, // apb write data
	input wire logic [31:0] prdata, // apb read data
	input wire logic pready, // apb ready
	input wire logic pslverr, // apb error
	input wire logic switch_privilege_level, // main bank allowed
	input wire logic [3:0] link_out_valid, // word to neighbour
	input wire logic fabric_hold // fabric frozen
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// access decode; reads only judged on the permitted main bank
	wire logic acc = psel && penable;
	wire logic rd_acc = acc && !pwrite && switch_privilege_level;
	sequence ctl_write_s;
		acc && pwrite && switch_privilege_level && paddr == mesh_switch_pkg::off_control;
	endsequence
	pready_high_a: assert property (pready)
		else $error("pready dropped");
	idle_rdata_a: assert property (!(acc && !pwrite) |-> prdata == 32'h0)
		else $error("read data outside read access");
	hold_follow_a: assert property (ctl_write_s |=> fabric_hold == $past(pwdata[0]))
		else $error("fabric hold not taken from control write");
	frozen_quiet_a: assert property (fabric_hold && $past(fabric_hold) |-> link_out_valid == 4'h0)
		else $error("word left a frozen fabric");
	route_read_a: assert property (rd_acc && paddr == mesh_switch_pkg::off_route_select |-> prdata[31:15] == 17'h0)
		else $error("route reserved bits set");
	fill_read_a: assert property (rd_acc && paddr == mesh_switch_pkg::off_input_fill_counts |-> prdata[31:20] == 12'h0)
		else $error("fill count reserved bits set");
	credit_read_a: assert property (rd_acc && paddr == mesh_switch_pkg::off_output_credit_counts |-> prdata[31:20] == 12'h0)
		else $error("credit reserved bits set");
	ready_read_a: assert property (rd_acc && paddr == mesh_switch_pkg::off_rx_ready_flag |-> prdata[31:1] == 31'h0)
		else $error("ready flag reserved bits set");
	choice_read_a: assert property (rd_acc && paddr == mesh_switch_pkg::off_fifo_choice |-> prdata[31:3] == 29'h0)
		else $error("choice reserved bits set");
	priv_err_a: assert property (acc && !switch_privilege_level && paddr < mesh_switch_pkg::off_alt_bank |-> pslverr)
		else $error("main bank open without privilege");
	unmapped_err_a: assert property (acc && paddr > mesh_switch_pkg::off_irq_mask && paddr < mesh_switch_pkg::off_alt_bank |-> pslverr)
		else $error("unmapped access not refused");
endmodule // switch_regs_asserts
bind static_mesh_switch_state_regs switch_regs_asserts switch_regs_asserts_i (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .switch_privilege_level(switch_privilege_level),
	.link_out_valid(link_out_valid), .fabric_hold(fabric_hold));

// [design/fifo_access_if.sv]
`timescale 1ns/1ps
interface fifo_access_if #(parameter int data_w = 32);
	logic push;
	logic pop;
	logic [data_w-1:0] wdata;
	logic [data_w-1:0] rdata;
	logic [3:0] count;
	logic ready;
	modport owner (input push, input pop, input wdata, output rdata, output count, output ready);
	modport user (output push, output pop, output wdata, input rdata, input count, input ready);
endinterface

// [design/mesh_switch_pkg.sv]
package mesh_switch_pkg;
	// register byte offsets on the bus
	localparam logic [7:0] off_control = 8'h00;
	localparam logic [7:0] off_fifo_port = 8'h04;
	localparam logic [7:0] off_fifo_choice = 8'h08;
	localparam logic [7:0] off_input_fill_counts = 8'h0c;
	localparam logic [7:0] off_output_credit_counts = 8'h10;
	localparam logic [7:0] off_route_select = 8'h14;
	localparam logic [7:0] off_rx_ready_flag = 8'h18;
	localparam logic [7:0] off_irq_status = 8'h1c;
	localparam logic [7:0] off_irq_mask = 8'h20;
	// duplicate set sits one bank higher
	localparam logic [7:0] off_alt_bank = 8'h40;
	localparam logic [7:0] off_alt_mask = 8'hc0;
	// fifo choice codes
	localparam logic [2:0] sel_north_in = 3'h0;
	localparam logic [2:0] sel_east_in = 3'h1;
	localparam logic [2:0] sel_south_in = 3'h2;
	localparam logic [2:0] sel_west_in = 3'h3;
	localparam logic [2:0] sel_proc_in = 3'h4;
	localparam logic [2:0] sel_proc_out = 3'h5;
	// route selector codes
	localparam logic [2:0] route_none = 3'h0;
	localparam logic [2:0] route_proc = 3'h5;
	// field layout
	localparam int count_field_w = 4;
	localparam int route_field_w = 3;
	localparam int num_ports = 5;
	localparam int choice_w = 3;
	localparam int fabric_hold_bit = 0;
	localparam int rx_ready_bit = 0;
	// reset values
	localparam logic [31:0] control_reset = 32'h0000_0001;
	localparam logic [31:0] zero_reset = 32'h0000_0000;
	// interrupt status bits
	localparam int irq_rx_ready = 0;
	localparam int irq_bad_choice = 1;
	localparam int irq_w = 2;
endpackage

// [design/route_mux.sv]
`timescale 1ns/1ps
module route_mux #(
	parameter int data_w = 32
) (
	input wire logic [2:0] route, // selector code
	input wire logic [5*data_w-1:0] in_words, // input heads n,e,s,w,p
	input wire logic [4:0] in_valid, // input head valid
	input wire logic hold, // fabric frozen
	output logic [data_w-1:0] out_word, // chosen word
	output logic out_valid, // chosen word valid
	output logic [4:0] in_take // which input it draws from
);
	// code 0 connects nothing; codes above 5 also drop out
	wire logic code_ok = (route != mesh_switch_pkg::route_none) &&
		(route <= mesh_switch_pkg::route_proc);
	wire logic [2:0] idx = route - 3'h1;
	assign out_word = code_ok ? in_words[idx*data_w +: data_w] : '0;
	assign out_valid = code_ok & ~hold & in_valid[idx];
	assign in_take = out_valid ? (5'h01 << idx) : 5'h00;
endmodule // route_mux

// [design/static_mesh_switch_state_regs.sv]
`timescale 1ns/1ps
module static_mesh_switch_state_regs #(
	parameter bit large_variant = 1'b1,
	parameter int data_w = 32,
	parameter int fifo_depth = 4
) (
	input wire logic pclk, // core clock
	input wire logic presetn, // async reset, low
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction
	input wire logic [7:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	input wire logic [2:0] pprot, // apb protection
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error
	input wire logic switch_privilege_level, // main set allowed
	input wire logic alt_switch_privilege_level, // duplicate set allowed
	input wire logic [4*data_w-1:0] link_in_data, // words from n,e,s,w
	input wire logic [3:0] link_in_valid, // neighbour word valid
	output logic [3:0] link_in_ready, // room in input fifos
	output logic [4*data_w-1:0] link_out_data, // words to n,e,s,w
	output logic [3:0] link_out_valid, // word to neighbour valid
	input wire logic [3:0] link_credit_return, // neighbour freed a slot
	output logic fabric_hold, // fabric frozen
	output logic irq // level interrupt
);
	localparam int cnt_w = $clog2(fifo_depth + 1);
	localparam int irq_w_l = mesh_switch_pkg::irq_w;

	// registers
	logic [31:0] control;
	logic [2:0] fifo_choice;
	logic [14:0] route_select;
	logic [3:0] credit [4];
	logic [irq_w_l-1:0] irq_status;
	logic [irq_w_l-1:0] irq_mask;

	// apb decode
	wire logic access = psel & penable;
	wire logic alt_hit = (paddr & mesh_switch_pkg::off_alt_mask) == mesh_switch_pkg::off_alt_bank;
	wire logic [7:0] reg_off = alt_hit ? (paddr - mesh_switch_pkg::off_alt_bank) : paddr;
	wire logic alt_ok = large_variant & alt_switch_privilege_level;
	wire logic bank_ok = alt_hit ? alt_ok : switch_privilege_level;
	wire logic hit_ctl = reg_off == mesh_switch_pkg::off_control;
	wire logic hit_port = reg_off == mesh_switch_pkg::off_fifo_port;
	wire logic hit_choice = reg_off == mesh_switch_pkg::off_fifo_choice;
	wire logic hit_in = reg_off == mesh_switch_pkg::off_input_fill_counts;
	wire logic hit_out = reg_off == mesh_switch_pkg::off_output_credit_counts;
	wire logic hit_route = reg_off == mesh_switch_pkg::off_route_select;
	wire logic hit_rdy = reg_off == mesh_switch_pkg::off_rx_ready_flag;
	wire logic hit_ist = !alt_hit && reg_off == mesh_switch_pkg::off_irq_status;
	wire logic hit_imk = !alt_hit && reg_off == mesh_switch_pkg::off_irq_mask;
	wire logic mapped = hit_ctl | hit_port | hit_choice | hit_in | hit_out | hit_route |
		hit_rdy | hit_ist | hit_imk;
	wire logic good = access & mapped & bank_ok;
	wire logic wr = good & pwrite;
	wire logic rd = good & ~pwrite;

	// choice decode used by several paths
	function automatic logic [5:0] choice_onehot(input logic [2:0] c);
		choice_onehot = (c <= mesh_switch_pkg::sel_proc_out) ? (6'h01 << c) : 6'h00;
	endfunction
	wire logic [5:0] chosen = choice_onehot(fifo_choice);
	wire logic bad_choice = chosen == 6'h00;
	wire logic port_rd = rd & hit_port & ~bad_choice;
	wire logic port_wr = wr & hit_port & ~bad_choice;

	// fifo instances: index 0-4 inputs, 5 processor output
	fifo_access_if #(.data_w(data_w)) fa [6] ();
	logic [6*data_w-1:0] heads;
	logic [5:0] fifo_rdy;
	logic [3:0] cnt [6];
	logic [4:0] take [5];
	logic [4:0] drawn;
	logic [5*data_w-1:0] out_words;
	logic [4:0] out_valid;
	logic [4:0] out_go;
	logic proc_out_full;

	genvar g;
	generate
		for (g = 0; g < 6; g++)
		begin : g_fifo
			logic net_push;
			logic net_pop;
			logic [data_w-1:0] net_word;
			assign fa[g].push = port_wr & chosen[g];
			assign fa[g].pop = port_rd & chosen[g];
			assign fa[g].wdata = pwdata;
			assign heads[g*data_w +: data_w] = fa[g].rdata;
			assign fifo_rdy[g] = fa[g].ready;
			assign cnt[g] = fa[g].count;
			if (g < 4)
			begin : g_link
				assign net_push = link_in_valid[g] & link_in_ready[g];
				assign net_word = link_in_data[g*data_w +: data_w];
				assign net_pop = drawn[g];
				// no room offered while software pushes, the fifo takes one word a cycle
				assign link_in_ready[g] = (cnt[g] < 4'(fifo_depth)) & ~fa[g].push;
			end
			else if (g == 4)
			begin : g_proc_in
				assign net_push = 1'b0;
				assign net_word = '0;
				assign net_pop = drawn[4];
			end
			else
			begin : g_proc_out
				assign net_push = out_go[4];
				assign net_word = out_words[4*data_w +: data_w];
				assign net_pop = 1'b0;
			end
			switch_fifo #(.data_w(data_w), .depth(fifo_depth), .cnt_w(cnt_w)) u_fifo (
				.pclk(pclk),
				.presetn(presetn),
				.net_push(net_push),
				.net_wdata(net_word),
				.net_pop(net_pop),
				.sw(fa[g].owner)
			);
		end
	endgenerate

	// a head that software pops this cycle is not offered to the fabric too
	wire logic [4:0] fabric_rdy = fifo_rdy[4:0] & ~(port_rd ? chosen[4:0] : 5'h00);

	// one mux per output port, steered by its route selector
	generate
		for (g = 0; g < 5; g++)
		begin : g_route
			route_mux #(.data_w(data_w)) u_mux (
				.route(route_select[g*3 +: 3]),
				.in_words(heads[5*data_w-1:0]),
				.in_valid(fabric_rdy),
				.hold(fabric_hold),
				.out_word(out_words[g*data_w +: data_w]),
				.out_valid(out_valid[g]),
				.in_take(take[g])
			);
		end
	endgenerate

	// a compass output moves only with credit, the processor output only with fifo room; an input feeding several outputs
	// pops once per cycle, whichever of them could take the word
	assign proc_out_full = cnt[5] >= 4'(fifo_depth);
	always_comb
	begin
		out_go = 5'h00;
		for (int i = 0; i < 4; i++)
			out_go[i] = out_valid[i] & (credit[i] != 4'h0);
		// a software push to the same fifo would otherwise swallow this word
		out_go[4] = out_valid[4] & ~proc_out_full & ~fa[5].push;
		drawn = 5'h00;
		for (int i = 0; i < 5; i++)
			drawn = drawn | (out_go[i] ? take[i] : 5'h00);
	end

	// outbound compass words are registered
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			link_out_data <= '0;
			link_out_valid <= 4'h0;
		end
		else
		begin
			link_out_data <= out_words[4*data_w-1:0];
			link_out_valid <= out_go[3:0];
		end
	end

	// width trim for the small variant
	function automatic logic [3:0] trim(input logic [3:0] v, input bit proc);
		if (large_variant)
			trim = v;
		else
			trim = proc ? {1'b0, v[2:0]} : {2'b00, v[1:0]};
	endfunction

	// state register views
	wire logic [31:0] in_view = {12'h000, trim(cnt[4], 1'b1), trim(cnt[3], 1'b0),
		trim(cnt[2], 1'b0), trim(cnt[1], 1'b0), trim(cnt[0], 1'b0)};
	wire logic [31:0] out_view = {12'h000, trim(cnt[5], 1'b1), trim(credit[3], 1'b0),
		trim(credit[2], 1'b0), trim(credit[1], 1'b0), trim(credit[0], 1'b0)};
	wire logic rx_ready = fifo_rdy[5];
	assign fabric_hold = control[mesh_switch_pkg::fabric_hold_bit];

	// credits: software may load them, returns add, sends subtract
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			for (int i = 0; i < 4; i++)
				credit[i] <= 4'h0;
		else
			for (int i = 0; i < 4; i++)
				if (wr && hit_out)
					credit[i] <= trim(pwdata[i*4 +: 4], 1'b0);
				else
					credit[i] <= credit[i] + 4'(link_credit_return[i]) - 4'(out_go[i]);
	end

	// control, choice and routes
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			control <= mesh_switch_pkg::control_reset;
			fifo_choice <= mesh_switch_pkg::sel_north_in;
			route_select <= '0;
			irq_mask <= '0;
		end
		else if (wr)
		begin
			if (hit_ctl)
				control <= {31'h0, pwdata[mesh_switch_pkg::fabric_hold_bit]};
			if (hit_choice)
				fifo_choice <= pwdata[2:0];
			if (hit_route)
				route_select <= pwdata[14:0];
			if (hit_imk)
				irq_mask <= pwdata[irq_w_l-1:0];
		end
	end

	// sticky events; a new event beats a write-one clear
	wire logic [irq_w_l-1:0] events = {access & hit_port & bank_ok & bad_choice, rx_ready};
	wire logic [irq_w_l-1:0] clr = (wr && hit_ist) ? pwdata[irq_w_l-1:0] : '0;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_status <= '0;
		else
			irq_status <= (irq_status & ~clr) | events;
	end
	assign irq = |(irq_status & irq_mask);

	// read mux; unmapped or refused answers zero with error
	wire logic [31:0] rd_word =
		hit_ctl ? control :
		hit_port ? (bad_choice ? 32'h0 : heads[fifo_choice*data_w +: 32]) :
		hit_choice ? {29'h0, fifo_choice} :
		hit_in ? in_view :
		hit_out ? out_view :
		hit_route ? {17'h0, route_select} :
		hit_rdy ? {31'h0, rx_ready} :
		hit_ist ? {30'h0, irq_status} :
		hit_imk ? {30'h0, irq_mask} : 32'h0;
	assign prdata = rd ? rd_word : 32'h0;
	assign pready = 1'b1;
	assign pslverr = access & ~(mapped & bank_ok);
endmodule // static_mesh_switch_state_regs

// [design/switch_fifo.sv]
`timescale 1ns/1ps
module switch_fifo #(
	parameter int data_w = 32,
	parameter int depth = 4,
	parameter int cnt_w = 3
) (
	input wire logic pclk, // core clock
	input wire logic presetn, // async reset, low
	input wire logic net_push, // write from fabric side
	input wire logic [data_w-1:0] net_wdata, // fabric word
	input wire logic net_pop, // read from fabric side
	fifo_access_if.owner sw // software access
);
	localparam int aw = $clog2(depth);
	logic [data_w-1:0] mem [depth];
	logic [aw-1:0] rd_ptr;
	logic [aw-1:0] wr_ptr;
	logic [cnt_w-1:0] fill;
	wire logic any_push = sw.push | net_push;
	wire logic any_pop = sw.pop | net_pop;
	wire logic full = (fill == cnt_w'(depth));
	wire logic empty = (fill == '0);
	wire logic do_push = any_push & ~full;
	wire logic do_pop = any_pop & ~empty;
	wire logic [data_w-1:0] push_word = sw.push ? sw.wdata : net_wdata;

	// software word wins over fabric word when both push
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rd_ptr <= '0;
			wr_ptr <= '0;
			fill <= '0;
		end
		else
		begin
			if (do_push)
				wr_ptr <= (wr_ptr == aw'(depth - 1)) ? '0 : wr_ptr + 1'b1;
			if (do_pop)
				rd_ptr <= (rd_ptr == aw'(depth - 1)) ? '0 : rd_ptr + 1'b1;
			fill <= fill + cnt_w'(do_push) - cnt_w'(do_pop);
		end
	end

	// storage has no reset, only the pointers matter
	always_ff @(posedge pclk)
	begin
		if (do_push)
			mem[wr_ptr] <= push_word;
	end

	assign sw.rdata = empty ? '0 : mem[rd_ptr];
	assign sw.count = 4'(fill);
	assign sw.ready = ~empty;
endmodule // switch_fifo
